// ---- hdl/mcp_pkg.sv ----
package mcp_pkg;
	localparam int ACC_W = 40;
	localparam int WORD_W = 32;
	localparam int HALF_W = 16;
	localparam int HI_W = ACC_W - WORD_W;
	localparam logic [ACC_W-1:0] ACC_RESET = 40'h00_0000_0000;
	// Half selects within a 32-bit operand
	localparam int HALF_HI_LSB = 16;
	localparam int HALF_LO_LSB = 0;
	// Operation codes issued by the core
	typedef enum logic [2:0] {
		MCP_OP_NONE = 3'h0,
		MCP_OP_HALF = 3'h1,
		MCP_OP_DUAL = 3'h2,
		MCP_OP_FULL = 3'h3,
		MCP_OP_TO_REGS = 3'h4,
		MCP_OP_FROM_REGS = 3'h5,
		MCP_OP_STORE = 3'h6,
		MCP_OP_LOAD = 3'h7
	} mcp_op_t;
	// Store/load transfer sequencer, one-hot
	typedef enum logic [2:0] {
		MCP_XF_IDLE = 3'h1,
		MCP_XF_STORE2 = 3'h2,
		MCP_XF_LOAD2 = 3'h4
	} mcp_xfer_t;
endpackage

// ---- hdl/mcp_mul_if.sv ----
`timescale 1ns/100ps
interface mcp_mul_if;
	logic [mcp_pkg::WORD_W-1:0] op_a;
	logic [mcp_pkg::WORD_W-1:0] op_b;
	logic [mcp_pkg::ACC_W-1:0] acc;
	logic [1:0] half_sel;
	mcp_pkg::mcp_op_t op;
	logic [mcp_pkg::ACC_W-1:0] sum;
	modport ctrl (output op_a, output op_b, output acc, output half_sel, output op, input sum);
	modport dp (input op_a, input op_b, input acc, input half_sel, input op, output sum);
endinterface

// ---- hdl/mcp_mul.sv ----
`timescale 1ns/100ps
module mcp_mul (
	mcp_mul_if.dp bus
);
	localparam int AW = mcp_pkg::ACC_W;
	localparam int HW = mcp_pkg::HALF_W;
	// =====================================
	// Operand selection
	wire signed [HW-1:0] a_hi = bus.op_a[mcp_pkg::HALF_HI_LSB +: HW];
	wire signed [HW-1:0] a_lo = bus.op_a[mcp_pkg::HALF_LO_LSB +: HW];
	wire signed [HW-1:0] b_hi = bus.op_b[mcp_pkg::HALF_HI_LSB +: HW];
	wire signed [HW-1:0] b_lo = bus.op_b[mcp_pkg::HALF_LO_LSB +: HW];
	wire signed [HW-1:0] sel_a = bus.half_sel[1] ? a_hi : a_lo;
	wire signed [HW-1:0] sel_b = bus.half_sel[0] ? b_hi : b_lo;
	// =====================================
	// Signed products
	wire signed [2*HW-1:0] prod_half = sel_a * sel_b;
	wire signed [2*HW-1:0] prod_hh = a_hi * b_hi;
	wire signed [2*HW-1:0] prod_ll = a_lo * b_lo;
	wire signed [2*mcp_pkg::WORD_W-1:0] prod_full = $signed(bus.op_a) * $signed(bus.op_b);
	wire [AW-1:0] ext_half = AW'(prod_half);
	wire [AW-1:0] ext_dual = AW'(prod_hh) + AW'(prod_ll);
	wire [AW-1:0] low_full = prod_full[AW-1:0];
	// Sum wraps modulo 2**40, no saturation
	assign bus.sum = (bus.op == mcp_pkg::MCP_OP_HALF) ? bus.acc + ext_half :
		(bus.op == mcp_pkg::MCP_OP_DUAL) ? bus.acc + ext_dual :
		bus.acc + low_full;
endmodule

// ---- hdl/mcp_top.sv ----
`timescale 1ns/100ps
// Overview of operation
// - One 40-bit accumulator; all multiplies signed in three operand forms.
// - Accumulator-to-registers transfer returns all 40 accumulator bits in two words.
// - Registers-to-accumulator transfer loads 40 bits from two supplied words.
// - Memory save or restore uses a pair of store or load transfers.
// - Half-select form picks halves, signed 32-bit product, sign-extended, accumulated.
// - Dual form multiplies high pair and low pair, both added sign-extended.
// - Full form adds the low 40 bits of the signed 64-bit product.
// - Every multiply-accumulate issued outside a store or load pair completes in one clock cycle; one issued inside a pair is refused.
module mcp_top (
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic issue_in,
	input wire logic [2:0] op_in,
	input wire logic [1:0] half_sel_in,
	input wire logic [31:0] rn_in,
	input wire logic [31:0] rs_in,
	output logic [31:0] reg_lo_out,
	output logic [31:0] reg_hi_out,
	output logic reg_valid_out,
	output logic [31:0] store_data_out,
	output logic store_valid_out,
	output logic [39:0] acc_out,
	output logic busy_out,
	output logic pair_error_out
);
	localparam int AW = mcp_pkg::ACC_W;
	localparam int WW = mcp_pkg::WORD_W;
	localparam int HW = mcp_pkg::HI_W;
	// =====================================
	// Reset release
	logic rst_s1;
	logic rstn;
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_s1 <= 1'b0;
			rstn <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rstn <= rst_s1;
		end
	end
	// =====================================
	// Decode
	mcp_pkg::mcp_op_t op;
	assign op = mcp_pkg::mcp_op_t'(op_in);
	logic [AW-1:0] acc;
	mcp_pkg::mcp_xfer_t xf;
	mcp_pkg::mcp_xfer_t next_xf;
	wire is_mac = issue_in && (op == mcp_pkg::MCP_OP_HALF || op == mcp_pkg::MCP_OP_DUAL ||
		op == mcp_pkg::MCP_OP_FULL);
	wire is_to = issue_in && op == mcp_pkg::MCP_OP_TO_REGS;
	wire is_from = issue_in && op == mcp_pkg::MCP_OP_FROM_REGS;
	wire is_st = issue_in && op == mcp_pkg::MCP_OP_STORE;
	wire is_ld = issue_in && op == mcp_pkg::MCP_OP_LOAD;
	wire [WW-1:0] hi_word = {{(WW-HW){acc[AW-1]}}, acc[AW-1:WW]};
	// =====================================
	// Multiply-accumulate datapath
	mcp_mul_if mif();
	assign mif.op_a = rn_in;
	assign mif.op_b = rs_in;
	assign mif.acc = acc;
	assign mif.half_sel = half_sel_in;
	assign mif.op = op;
	mcp_mul u_mul (
		.bus(mif.dp)
	);
	// =====================================
	// Paired transfer sequencing
	always_comb begin
		next_xf = xf;
		case (xf)
			mcp_pkg::MCP_XF_IDLE: begin
				if (is_st) begin
					next_xf = mcp_pkg::MCP_XF_STORE2;
				end else if (is_ld) begin
					next_xf = mcp_pkg::MCP_XF_LOAD2;
				end
			end
			mcp_pkg::MCP_XF_STORE2: begin
				if (issue_in) begin
					next_xf = mcp_pkg::MCP_XF_IDLE;
				end
			end
			mcp_pkg::MCP_XF_LOAD2: begin
				if (issue_in) begin
					next_xf = mcp_pkg::MCP_XF_IDLE;
				end
			end
			default: next_xf = mcp_pkg::MCP_XF_IDLE;
		endcase
	end
	wire in_pair = xf != mcp_pkg::MCP_XF_IDLE;
	wire pair_ok = (xf == mcp_pkg::MCP_XF_STORE2 && is_st) ||
		(xf == mcp_pkg::MCP_XF_LOAD2 && is_ld);
	wire pair_bad = in_pair && issue_in && !pair_ok;
	logic [WW-1:0] load_lo;
	// =====================================
	// Accumulator and state
	always_ff @(posedge clock_in or negedge rstn) begin
		if (!rstn) begin
			acc <= mcp_pkg::ACC_RESET;
			xf <= mcp_pkg::MCP_XF_IDLE;
			load_lo <= '0;
		end else begin
			xf <= next_xf;
			if (!in_pair && is_ld) begin
				load_lo <= rn_in;
			end
			if (pair_ok && is_ld) begin
				acc <= {rn_in[HW-1:0], load_lo};
			end else if (!in_pair && is_mac) begin
				acc <= mif.sum;
			end else if (!in_pair && is_from) begin
				acc <= {rs_in[HW-1:0], rn_in};
			end
		end
	end
	// =====================================
	// Outputs
	always_ff @(posedge clock_in or negedge rstn) begin
		if (!rstn) begin
			reg_lo_out <= '0;
			reg_hi_out <= '0;
			reg_valid_out <= 1'b0;
			store_data_out <= '0;
			store_valid_out <= 1'b0;
			pair_error_out <= 1'b0;
			busy_out <= 1'b0;
		end else begin
			reg_valid_out <= !in_pair && is_to;
			if (!in_pair && is_to) begin
				reg_lo_out <= acc[WW-1:0];
				reg_hi_out <= hi_word;
			end
			store_valid_out <= is_st && (!in_pair || pair_ok);
			if (is_st && !in_pair) begin
				store_data_out <= acc[WW-1:0];
			end else if (is_st && pair_ok) begin
				store_data_out <= hi_word;
			end
			pair_error_out <= pair_bad;
			// Registered from the next state so busy leaves a flop in step with xf
			busy_out <= next_xf != mcp_pkg::MCP_XF_IDLE;
		end
	end
	assign acc_out = acc;
	// =====================================
	// Checks
	sequence s_to_req;
		!in_pair && is_to;
	endsequence
	sequence s_store_second;
		pair_ok && is_st;
	endsequence
	sequence s_load_first;
		!in_pair && is_ld;
	endsequence
	sequence s_load_second;
		pair_ok && is_ld;
	endsequence
	chk_to_regs_lo: assert property (@(posedge clock_in) disable iff (!rstn)
		s_to_req |=> reg_valid_out && reg_lo_out == $past(acc[WW-1:0]))
		else $error("low word of accumulator transfer wrong");
	chk_hi_sign: assert property (@(posedge clock_in) disable iff (!rstn)
		reg_valid_out |-> reg_hi_out[WW-1:HW] == {(WW-HW){reg_hi_out[HW-1]}})
		else $error("high word not sign-extended");
	chk_from_regs: assert property (@(posedge clock_in) disable iff (!rstn)
		!in_pair && is_from |=> acc == {$past(rs_in[HW-1:0]), $past(rn_in)})
		else $error("accumulator load from registers wrong");
	chk_mac_one: assert property (@(posedge clock_in) disable iff (!rstn)
		!in_pair && is_mac |=> acc == $past(mif.sum))
		else $error("multiply-accumulate not done in one cycle");
	chk_full_low: assert property (@(posedge clock_in) disable iff (!rstn)
		!in_pair && issue_in && op == mcp_pkg::MCP_OP_FULL |=>
		acc == $past(acc) + 40'($signed(64'($signed($past(rn_in)))) *
		$signed(64'($signed($past(rs_in))))))
		else $error("full-word accumulate wrong");
	chk_dual_sum: assert property (@(posedge clock_in) disable iff (!rstn)
		!in_pair && issue_in && op == mcp_pkg::MCP_OP_DUAL |=>
		acc == $past(acc) + 40'($signed($past(rn_in[31:16])) * $signed($past(rs_in[31:16])))
		+ 40'($signed($past(rn_in[15:0])) * $signed($past(rs_in[15:0]))))
		else $error("dual accumulate wrong");
	chk_store_pair: assert property (@(posedge clock_in) disable iff (!rstn)
		!in_pair && is_st |=> busy_out && store_data_out == $past(acc[WW-1:0]))
		else $error("first store transfer wrong");
	chk_hold_acc: assert property (@(posedge clock_in) disable iff (!rstn)
		!issue_in |=> acc == $past(acc))
		else $error("accumulator changed with no operation");
	chk_half_wrap: assert property (@(posedge clock_in) disable iff (!rstn)
		!in_pair && issue_in && op == mcp_pkg::MCP_OP_HALF && half_sel_in == 2'h0 |=>
		acc == $past(acc) + 40'($signed($past(rn_in[15:0])) * $signed($past(rs_in[15:0]))))
		else $error("half-select accumulate wrong");
	chk_store_hi: assert property (@(posedge clock_in) disable iff (!rstn)
		s_store_second |=> store_valid_out && !busy_out && store_data_out == $past(hi_word))
		else $error("second store transfer wrong");
	chk_load_pair: assert property (@(posedge clock_in) disable iff (!rstn)
		s_load_first ##1 s_load_second |=> !busy_out && acc == {$past(rn_in[HW-1:0]), $past(rn_in, 2)})
		else $error("paired load did not restore accumulator");
	chk_load_first: assert property (@(posedge clock_in) disable iff (!rstn)
		s_load_first |=> busy_out && acc == $past(acc))
		else $error("first load transfer changed accumulator");
	chk_pair_abort: assert property (@(posedge clock_in) disable iff (!rstn)
		pair_bad |=> pair_error_out && !busy_out && acc == $past(acc))
		else $error("broken pair not refused");
	chk_pair_busy: assert property (@(posedge clock_in) disable iff (!rstn)
		!in_pair && (is_st || is_ld) |=> busy_out)
		else $error("pair start did not raise busy");
	chk_reg_pulse: assert property (@(posedge clock_in) disable iff (!rstn)
		reg_valid_out |-> $past(is_to && !in_pair))
		else $error("register transfer valid without request");
	chk_store_cause: assert property (@(posedge clock_in) disable iff (!rstn)
		store_valid_out |-> $past(is_st))
		else $error("store valid without store transfer");
	chk_hi_regs: assert property (@(posedge clock_in) disable iff (!rstn)
		s_to_req |=> reg_hi_out == $past(hi_word))
		else $error("high word of accumulator transfer wrong");
	chk_idle_quiet: assert property (@(posedge clock_in) disable iff (!rstn)
		!issue_in |=> !reg_valid_out && !store_valid_out && !pair_error_out)
		else $error("pulse output raised with no operation");
endmodule

// ---- dv/mcp_host.sv ----
`timescale 1ns/100ps
// ==========
// Core side issuing coprocessor operations
module mcp_host (
	input wire logic clock_in,
	output logic issue_out,
	output logic [2:0] op_out,
	output logic [1:0] half_sel_out,
	output logic [31:0] rn_out,
	output logic [31:0] rs_out
);
	initial begin
		issue_out = 1'b0;
		op_out = 3'h0;
		half_sel_out = 2'h0;
		rn_out = 32'h0;
		rs_out = 32'h0;
	end
	task automatic send(input logic [2:0] op, input logic [1:0] hs, input logic [31:0] a,
		input logic [31:0] b);
		@(posedge clock_in);
		issue_out <= 1'b1;
		op_out <= op;
		half_sel_out <= hs;
		rn_out <= a;
		rs_out <= b;
	endtask
	// Released operands do not keep their last value
	task automatic idle();
		@(posedge clock_in);
		issue_out <= 1'b0;
		rn_out <= ~rn_out;
		rs_out <= ~rs_out;
	endtask
	task automatic pair(input logic [2:0] op, input logic [39:0] v);
		send(op, 2'h0, v[31:0], 32'h0);
		send(op, 2'h0, {{24{v[39]}}, v[39:32]}, 32'h0);
	endtask
endmodule

// ---- dv/mac_coprocessor_40bit_acc_bench.sv ----
`timescale 1ns/100ps
module mac_coprocessor_40bit_acc_bench;
	typedef struct {logic [2:0] op; logic [1:0] hs; logic [31:0] a, b; logic [39:0] s;} mcp_row_t;
	logic clock_in, resetn_in, issue, rvld, svld, busy, perr;
	logic [2:0] op;
	logic [1:0] hs;
	logic [31:0] rn, rs, rlo, rhi, sdat;
	logic [39:0] acc, e;
	int error_cnt = 0;
	int checks_done = 0;
	mcp_row_t rows [8];
	mcp_host i_host (.clock_in(clock_in), .issue_out(issue), .op_out(op), .half_sel_out(hs),
		.rn_out(rn), .rs_out(rs));
	mcp_top i_dut (.clock_in(clock_in), .resetn_in(resetn_in), .issue_in(issue), .op_in(op),
		.half_sel_in(hs), .rn_in(rn), .rs_in(rs), .reg_lo_out(rlo), .reg_hi_out(rhi),
		.reg_valid_out(rvld), .store_data_out(sdat), .store_valid_out(svld), .acc_out(acc),
		.busy_out(busy), .pair_error_out(perr));
	// ==========
	// Expected accumulator after one row
	function automatic logic [39:0] model(mcp_row_t r);
		logic signed [15:0] x, y;
		logic signed [31:0] p, h, q;
		logic signed [63:0] w;
		x = r.hs[1] ? r.a[31:16] : r.a[15:0];
		y = r.hs[0] ? r.b[31:16] : r.b[15:0];
		p = x * y;
		h = $signed(r.a[31:16]) * $signed(r.b[31:16]);
		q = $signed(r.a[15:0]) * $signed(r.b[15:0]);
		w = $signed(r.a) * $signed(r.b);
		if (r.op == 3'h1) return r.s + {{8{p[31]}}, p};
		if (r.op == 3'h2) return r.s + {{8{h[31]}}, h} + {{8{q[31]}}, q};
		return r.s + w[39:0];
	endfunction
	task automatic cmp_val(input logic [39:0] got, input logic [39:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_flag(input logic got, input logic exp);
		cmp_val({39'h0, got}, {39'h0, exp});
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end
	initial begin
		#100us;
		error_cnt++;
		give_verdict();
	end
	// ==========
	// Row table, then pairs, broken pair and reset
	initial begin
		resetn_in = 1'b0;
		rows = '{'{3'h1, 2'h0, 32'h8000_7fff, 32'hfffe_0003, 40'h10},
			'{3'h1, 2'h1, 32'h8000_7fff, 32'hfffe_0003, 40'h10},
			'{3'h1, 2'h2, 32'h8000_7fff, 32'hfffe_0003, 40'h10},
			'{3'h1, 2'h3, 32'h8000_7fff, 32'hfffe_0003, 40'h10},
			'{3'h2, 2'h0, 32'h8000_0005, 32'h8000_fffd, 40'hff_ffff_fff0},
			'{3'h3, 2'h0, 32'h8000_0000, 32'h7fff_ffff, 40'h0},
			'{3'h3, 2'h0, 32'hffff_ffff, 32'hffff_ffff, 40'hff_ffff_ffff},
			'{3'h1, 2'h0, 32'h0000_7fff, 32'h0000_7fff, 40'h7f_ffff_ffff}};
		repeat (2) @(posedge clock_in);
		resetn_in <= 1'b1;
		#1;
		cmp_val(acc, 40'h0);
		cmp_val({36'h0, rvld, svld, busy, perr}, 40'h0);
		repeat (2) @(posedge clock_in);
		foreach (rows[i]) begin
			e = model(rows[i]);
			i_host.send(3'h5, 2'h0, rows[i].s[31:0], {24'h0, rows[i].s[39:32]});
			i_host.send(rows[i].op, rows[i].hs, rows[i].a, rows[i].b);
			#1;
			cmp_val(acc, rows[i].s);
			i_host.send(3'h4, 2'h0, 32'h0, 32'h0);
			#1;
			cmp_val(acc, e);
			i_host.idle();
			#1;
			cmp_flag(rvld, 1'b1);
			cmp_val(rlo, e[31:0]);
			cmp_val(rhi, {{24{e[39]}}, e[39:32]});
		end
		i_host.send(3'h5, 2'h0, 32'h89ab_cdef, 32'h0000_0080);
		#1;
		cmp_flag(rvld, 1'b0);
		i_host.pair(3'h6, 40'h0);
		#1;
		cmp_flag(svld & busy, 1'b1);
		cmp_val(sdat, 32'h89ab_cdef);
		i_host.send(3'h7, 2'h0, 32'h3456_789a, 32'h0);
		#1;
		cmp_val({svld, busy, sdat}, {2'h2, 32'hffff_ff80});
		i_host.send(3'h7, 2'h0, 32'h0000_0012, 32'h0);
		#1;
		cmp_val({busy, acc}, {1'b1, 40'h80_89ab_cdef});
		i_host.idle();
		#1;
		cmp_val({busy, acc}, {1'b0, 40'h12_3456_789a});
		i_host.send(3'h6, 2'h0, 32'h0, 32'h0);
		i_host.send(3'h1, 2'h3, 32'h0001_0000, 32'h0001_0000);
		#1;
		cmp_val({svld, busy, sdat}, {2'h3, 32'h3456_789a});
		i_host.idle();
		#1;
		cmp_val({perr, busy, acc}, {2'h2, 40'h12_3456_789a});
		@(posedge clock_in);
		resetn_in <= 1'b0;
		#1;
		cmp_val(acc, 40'h0);
		give_verdict();
	end
endmodule
